// File: inc/uctl2_defines.vh
// Purpose: Offsets, field positions, reset values and timing counts for the control block.
// Assumes: 100 MHz system clock, 8-bit register port.
// Notes: Included by bare name.
`ifndef UCTL2_DEFINES_VH
`define UCTL2_DEFINES_VH
`define UCTL2_ADDR_W 2
`define UCTL2_OFF_CTRL2 2'h0
`define UCTL2_OFF_CTRL1 2'h1
`define UCTL2_OFF_STAT 2'h2
`define UCTL2_OFF_BAUD 2'h3
`define UCTL2_CTRL2_RST 8'h00
`define UCTL2_CTRL1_RST 8'h00
`define UCTL2_BAUD_RST 8'h1B
`define UCTL2_B_XEMPTY_IRQ 7
`define UCTL2_B_XDONE_IRQ 6
`define UCTL2_B_RXFULL_IRQ 5
`define UCTL2_B_QUIET_IRQ 4
`define UCTL2_B_XMIT_ON 3
`define UCTL2_B_RCV_ON 2
`define UCTL2_B_STANDBY 1
`define UCTL2_B_BREAK 0
`define UCTL2_B_LOOP 7
`define UCTL2_B_RCV_SOURCE_SEL 5
`define UCTL2_B_NINE 4
`define UCTL2_B_ROUSE 3
`define UCTL2_B_LONGBRK 2
`define UCTL2_B_DIR 1
`define UCTL2_OVS 16
`define UCTL2_BRK_SHORT 10
`define UCTL2_BRK_LONG 13
`define UCTL2_IDLE_CHAR 10
`endif

// File: hw/uctl2_rx.v
// Purpose: Receive shifter with idle-line and wakeup detection.
// Assumes: Serial input already synchronised; tick is a 16x bit-rate enable.
// Notes: Standby suppresses the full flag until the wakeup condition is seen.
`include "uctl2_defines.vh"
module uctl2_rx (
   input wire sys_clk,
   input wire rst,
   input wire tick,
   input wire enable,
   input wire nine_bit,
   input wire rouse_method_sel,
   input wire rcv_standby,
   input wire rx_line,
   output reg [8:0] rx_data_r,
   output reg char_done_r,
   output reg wake_r,
   output reg quiet_r
);
   reg [3:0] sub_r;
   reg [3:0] bit_r;
   reg busy_r;
   reg [8:0] sh_r;
   reg [8:0] idle_cnt_r;
   reg active_r;
   wire [3:0] last_bit = nine_bit ? 4'hA : 4'h9;
   wire [8:0] idle_need = (nine_bit ? 9'h00B : 9'h00A) * 9'h010;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sub_r <= 4'h0;
         bit_r <= 4'h0;
         busy_r <= 1'b0;
         sh_r <= 9'h000;
         rx_data_r <= 9'h000;
         char_done_r <= 1'b0;
         wake_r <= 1'b0;
         quiet_r <= 1'b0;
         idle_cnt_r <= 9'h000;
         active_r <= 1'b0;
      end else begin
         char_done_r <= 1'b0;
         wake_r <= 1'b0;
         quiet_r <= 1'b0;
         if (!enable) begin
            busy_r <= 1'b0;
            idle_cnt_r <= 9'h000;
         end else if (tick) begin
            if (!busy_r) begin
               if (!rx_line) begin
                  busy_r <= 1'b1;
                  sub_r <= 4'h0;
                  bit_r <= 4'h0;
                  active_r <= 1'b1;
               end
               if (rx_line && active_r) begin
                  // Idle line: one full character of marks after activity.
                  if (idle_cnt_r == idle_need - 9'h001) begin
                     idle_cnt_r <= 9'h000;
                     active_r <= 1'b0;
                     quiet_r <= ~rcv_standby;
                     wake_r <= rcv_standby & ~rouse_method_sel;
                  end else begin
                     idle_cnt_r <= idle_cnt_r + 9'h001;
                  end
               end else begin
                  idle_cnt_r <= 9'h000;
               end
            end else begin
               sub_r <= sub_r + 4'h1;
               if (sub_r == 4'h7) begin
                  if (bit_r == 4'h0 && rx_line) begin
                     busy_r <= 1'b0;
                  end else if (bit_r == last_bit) begin
                     busy_r <= 1'b0;
                     rx_data_r <= nine_bit ? sh_r : {1'b0, sh_r[8:1]};
                     // Address mark: data MSB is one.
                     if (rcv_standby && rouse_method_sel) begin
                        wake_r <= nine_bit ? sh_r[8] : sh_r[8];
                        char_done_r <= sh_r[8];
                     end else begin
                        char_done_r <= ~rcv_standby;
                     end
                  end else begin
                     if (bit_r != 4'h0) begin
                        sh_r <= {rx_line, sh_r[8:1]};
                     end
                     bit_r <= bit_r + 4'h1;
                  end
               end
            end
         end
      end
   end
endmodule

// File: hw/uctl2_top.v
// Purpose: Serial port second control register and the transmit, pin and interrupt logic it steers.
// Assumes: Register port with one-cycle read latency, 100 MHz clock, 8-bit data.
// Notes: Pin enables are active low; serial pins use three-stage synchronisers.
//
// Our own choices: the plain strobed port and the register offsets.
`include "uctl2_defines.vh"
module uctl2_top (
   input wire sys_clk,
   input wire rst,
   input wire [`UCTL2_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_r,
   input wire [8:0] xmit_data,
   input wire xmit_load,
   output wire xmit_ready,
   output wire [8:0] rcv_data,
   input wire rcv_taken,
   input wire serial_out_in,
   output reg serial_out_o,
   output reg serial_out_oe_n,
   input wire serial_in_in,
   output wire serial_in_owned,
   output wire irq
);
   localparam S_IDLE = 4'b0001;
   localparam S_DATA = 4'b0010;
   localparam S_BRK = 4'b0100;
   localparam S_PRE = 4'b1000;
   reg [7:0] ctrl2_r;
   reg [7:0] ctrl1_r;
   reg [7:0] baud_r;
   reg [7:0] bdiv_r;
   reg tick;
   reg [2:0] sin_sync_r;
   reg [2:0] sout_sync_r;
   reg sin_r;
   reg sout_r;
   reg xempty_r;
   reg xdone_r;
   reg rfull_r;
   reg quiet_r;
   reg [8:0] xbuf_r;
   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg [3:0] sub_r;
   reg [3:0] cnt_r;
   reg [10:0] sh_r;
   reg idle_q_r;
   reg brk_q_r;
   reg pin_hold_r;
   wire xmit_on = ctrl2_r[`UCTL2_B_XMIT_ON];
   wire rcv_on = ctrl2_r[`UCTL2_B_RCV_ON];
   wire loop = ctrl1_r[`UCTL2_B_LOOP];
   wire single = loop & ctrl1_r[`UCTL2_B_RCV_SOURCE_SEL];
   wire nine = ctrl1_r[`UCTL2_B_NINE];
   wire [3:0] brk_len = ctrl1_r[`UCTL2_B_LONGBRK] ?
      4'd`UCTL2_BRK_LONG : 4'd`UCTL2_BRK_SHORT;
   wire [3:0] frm_len = nine ? 4'd11 : 4'd10;
   wire ctl_wr = reg_wr && reg_addr == `UCTL2_OFF_CTRL2;
   wire [8:0] rx_word;
   wire rx_done;
   wire rx_wake;
   wire rx_quiet;
   wire rx_line;
   wire tx_busy = state_r != S_IDLE;
   wire tx_line = (state_r == S_DATA) ? sh_r[0] : (state_r == S_BRK) ? 1'b0 : 1'b1;
   // Baud enable at 16x bit rate from the divisor register.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bdiv_r <= 8'h00;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (bdiv_r >= baud_r - 8'h01) begin
            bdiv_r <= 8'h00;
            tick <= baud_r != 8'h00;
         end else begin
            bdiv_r <= bdiv_r + 8'h01;
         end
      end
   end
   // Only the second and third stages are compared.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sin_sync_r <= 3'b111;
         sout_sync_r <= 3'b111;
         sin_r <= 1'b1;
         sout_r <= 1'b1;
      end else begin
         sin_sync_r <= {sin_sync_r[1:0], serial_in_in};
         sout_sync_r <= {sout_sync_r[1:0], serial_out_in};
         if (sin_sync_r[1] == sin_sync_r[2]) sin_r <= sin_sync_r[2];
         if (sout_sync_r[1] == sout_sync_r[2]) sout_r <= sout_sync_r[2];
      end
   end
   // Internal loop feeds the receiver from the transmitter; single wire listens on the output pin.
   assign rx_line = !loop ? sin_r : single ? sout_r : tx_line;
   assign serial_in_owned = rcv_on & ~loop;
   uctl2_rx u_rx (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(tick),
      .enable(rcv_on),
      .nine_bit(nine),
      .rouse_method_sel(ctrl1_r[`UCTL2_B_ROUSE]),
      .rcv_standby(ctrl2_r[`UCTL2_B_STANDBY]),
      .rx_line(rx_line),
      .rx_data_r(rcv_data),
      .char_done_r(rx_done),
      .wake_r(rx_wake),
      .quiet_r(rx_quiet)
   );
   // Control registers; the write path never waits on link activity.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl2_r <= `UCTL2_CTRL2_RST;
         ctrl1_r <= `UCTL2_CTRL1_RST;
         baud_r <= `UCTL2_BAUD_RST;
      end else begin
         if (ctl_wr) ctrl2_r <= reg_wdata;
         else if (rx_wake) ctrl2_r[`UCTL2_B_STANDBY] <= 1'b0;
         if (reg_wr && reg_addr == `UCTL2_OFF_CTRL1) ctrl1_r <= reg_wdata;
         if (reg_wr && reg_addr == `UCTL2_OFF_BAUD) baud_r <= reg_wdata;
      end
   end
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `UCTL2_OFF_CTRL2: reg_rdata_r <= ctrl2_r;
            `UCTL2_OFF_CTRL1: reg_rdata_r <= ctrl1_r;
            `UCTL2_OFF_STAT: reg_rdata_r <= {xempty_r, xdone_r, rfull_r, quiet_r, 4'h0};
            `UCTL2_OFF_BAUD: reg_rdata_r <= baud_r;
            default: reg_rdata_r <= 8'h00;
         endcase
      end else begin
         reg_rdata_r <= 8'h00;
      end
   end
   // Queued idle and break requests; set wins over the consuming clear.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idle_q_r <= 1'b0;
         brk_q_r <= 1'b0;
      end else begin
         if (ctl_wr && !xmit_on && reg_wdata[`UCTL2_B_XMIT_ON] && (tx_busy || !xdone_r))
            idle_q_r <= 1'b1;
         else if (state_nxt == S_PRE && state_r != S_PRE)
            idle_q_r <= 1'b0;
         if (ctl_wr && ctrl2_r[`UCTL2_B_BREAK] && !reg_wdata[`UCTL2_B_BREAK])
            brk_q_r <= 1'b1;
         else if (state_nxt == S_BRK && state_r != S_BRK)
            brk_q_r <= 1'b0;
      end
   end
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (brk_q_r || (xmit_on && ctrl2_r[`UCTL2_B_BREAK])) state_nxt = S_BRK;
            else if (idle_q_r) state_nxt = S_PRE;
            else if (xmit_on && !xempty_r) state_nxt = S_DATA;
         end
         S_DATA, S_BRK, S_PRE: begin
            if (tick && sub_r == 4'hF && cnt_r == 4'h0) state_nxt = S_IDLE;
         end
         default: state_nxt = S_IDLE;
      endcase
   end
   // Clearing the break bit during a break queues one more, so a second may slip out.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= S_IDLE;
         sub_r <= 4'h0;
         cnt_r <= 4'h0;
         sh_r <= 11'h7FF;
         xbuf_r <= 9'h000;
         xempty_r <= 1'b1;
         xdone_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         if (xmit_load && xempty_r) begin
            xbuf_r <= xmit_data;
            xempty_r <= 1'b0;
         end
         if (state_r == S_IDLE && state_nxt != S_IDLE) begin
            sub_r <= 4'h0;
            if (state_nxt == S_DATA) begin
               sh_r <= nine ? {1'b1, xbuf_r, 1'b0} : {2'b11, xbuf_r[7:0], 1'b0};
               cnt_r <= frm_len - 4'h1;
               xempty_r <= 1'b1;
            end else if (state_nxt == S_BRK) begin
               cnt_r <= brk_len - (nine ? 4'h0 : 4'h1);
            end else begin
               cnt_r <= frm_len - 4'h1;
            end
         end else if (tick && tx_busy) begin
            sub_r <= sub_r + 4'h1;
            if (sub_r == 4'hF && cnt_r != 4'h0) begin
               cnt_r <= cnt_r - 4'h1;
               sh_r <= {1'b1, sh_r[10:1]};
            end
         end
         xdone_r <= xempty_r && !tx_busy && state_nxt == S_IDLE;
      end
   end
   always @(posedge sys_clk or posedge rst) begin
      if (rst) pin_hold_r <= 1'b0;
      else pin_hold_r <= xmit_on | tx_busy | idle_q_r | brk_q_r;
   end
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         serial_out_o <= 1'b1;
         serial_out_oe_n <= 1'b1;
      end else begin
         serial_out_o <= tx_line;
         if (single) serial_out_oe_n <= ~(pin_hold_r & ctrl1_r[`UCTL2_B_DIR]);
         else serial_out_oe_n <= ~pin_hold_r;
      end
   end
   // Receive-full and quiet flags; new events win over the consuming clear.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rfull_r <= 1'b0;
         quiet_r <= 1'b0;
      end else begin
         if (rx_done) rfull_r <= 1'b1;
         else if (rcv_taken) rfull_r <= 1'b0;
         if (rx_quiet) quiet_r <= 1'b1;
         else if (rcv_taken) quiet_r <= 1'b0;
      end
   end
   assign xmit_ready = xempty_r;
   assign irq = (ctrl2_r[`UCTL2_B_XEMPTY_IRQ] & xempty_r)
      | (ctrl2_r[`UCTL2_B_XDONE_IRQ] & xdone_r)
      | (ctrl2_r[`UCTL2_B_RXFULL_IRQ] & rfull_r)
      | (ctrl2_r[`UCTL2_B_QUIET_IRQ] & quiet_r);
endmodule

// File: verif/uctl2_properties.sv
// Purpose: Port-level checks of the control block.
// Assumes: Strobes never overlap.
// Notes: Both control registers are mirrored from bus writes.
`include "uctl2_defines.vh"
module uctl2_properties (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [`UCTL2_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_r,
   input wire logic xmit_ready,
   input wire logic serial_out_oe_n,
   input wire logic serial_in_owned,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] c2_r;
   logic [7:0] c1_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         c2_r <= 8'h00;
         c1_r <= 8'h00;
      end else if (reg_wr && reg_addr == `UCTL2_OFF_CTRL2) begin
         c2_r <= reg_wdata;
      end else if (reg_wr && reg_addr == `UCTL2_OFF_CTRL1) begin
         c1_r <= reg_wdata;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_rd_c2;
      reg_rd && reg_addr == `UCTL2_OFF_CTRL2;
   endsequence
   sequence s_tx_on;
      (c2_r[3] && !c1_r[7]) [*3];
   endsequence
   // The direction must have settled for three cycles before the pin is judged.
   sequence s_one_wire;
      (c2_r[3] && c1_r[7] && c1_r[5] && $stable(c1_r)) [*3];
   endsequence
   // Standby is masked because hardware may clear it.
   AST_RD_CTRL2: assert property (s_rd_c2 |=> (reg_rdata_r & 8'hfd) == (c2_r & 8'hfd))
      else $error("control read differs");
   AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata_r == 8'h00)
      else $error("stray read data");
   AST_IRQ_SRC: assert property (irq |-> c2_r[7:4] != 4'h0)
      else $error("interrupt without enable");
   AST_IRQ_EMPTY: assert property (c2_r[7] && xmit_ready |-> irq)
      else $error("empty interrupt missing");
   AST_RX_PIN: assert property (serial_in_owned == (c2_r[2] && !c1_r[7]))
      else $error("receive pin ownership wrong");
   AST_TX_PIN: assert property (s_tx_on |-> !serial_out_oe_n)
      else $error("transmit pin not driven");
   AST_ONE_WIRE: assert property (s_one_wire |-> serial_out_oe_n == !c1_r[1])
      else $error("single wire direction ignored");
   AST_RST_EMPTY: assert property ($fell(rst) |-> xmit_ready)
      else $error("buffer not empty after reset");
endmodule

// File: verif/uctl2_remote.sv
// Purpose: Remote serial node on the two serial lines.
// Assumes: 8 data bits, LSB first, one stop bit.
// Notes: Waits are bounded so that a silent line cannot hang the run.
module uctl2_remote #(parameter int BIT_CYC = 16) (
   input wire logic sys_clk,
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial line_out = 1'b1;
   task automatic send(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line_out <= f[i];
         repeat (BIT_CYC) @(posedge sys_clk);
      end
   endtask
   task automatic fall();
      int c;
      c = 0;
      while (line_in === 1'b1 && c < 4000) begin
         @(posedge sys_clk);
         c++;
      end
   endtask
   task automatic recv(output logic [7:0] d);
      fall();
      repeat (BIT_CYC + BIT_CYC / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         d[i] = line_in;
         repeat (BIT_CYC) @(posedge sys_clk);
      end
   endtask
   task automatic lowrun(output int n);
      int c;
      c = 0;
      fall();
      while (line_in === 1'b0 && c < 1000) begin
         @(posedge sys_clk);
         c++;
      end
      n = (c + BIT_CYC / 2) / BIT_CYC;
   endtask
endmodule

// File: verif/test_uart_control_two.sv
// Purpose: Self-checking bench for the serial port control block.
// Assumes: Baud divisor 1, so a bit lasts 16 clocks.
// Notes: The output line has a pull-up, so a released pin reads high.
`include "uctl2_defines.vh"
module test_uart_control_two;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT = 16;
   logic sys_clk = 1'b0;
   logic rst = 1'b0;
   logic [`UCTL2_ADDR_W-1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [8:0] xmit_data = 9'h000;
   logic xmit_load = 1'b0;
   logic rcv_taken = 1'b0;
   logic [7:0] reg_rdata_r;
   logic [8:0] rcv_data;
   logic xmit_ready;
   logic serial_out_o;
   logic serial_out_oe_n;
   logic serial_out_in;
   logic serial_in_in;
   logic serial_in_owned;
   logic irq;
   logic [8:0] v;
   logic [7:0] w;
   int n;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   assign serial_out_in = serial_out_oe_n ? 1'b1 : serial_out_o;
   always #5 sys_clk = ~sys_clk;
   uctl2_top uctl2_top_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
      .xmit_data(xmit_data), .xmit_load(xmit_load), .xmit_ready(xmit_ready),
      .rcv_data(rcv_data), .rcv_taken(rcv_taken), .serial_out_in(serial_out_in),
      .serial_out_o(serial_out_o), .serial_out_oe_n(serial_out_oe_n),
      .serial_in_in(serial_in_in), .serial_in_owned(serial_in_owned), .irq(irq));
   uctl2_remote #(.BIT_CYC(BIT)) uctl2_remote_i (.sys_clk(sys_clk),
      .line_in(serial_out_in), .line_out(serial_in_in));
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [1:0] a, output logic [8:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = {1'b0, reg_rdata_r};
      @(posedge sys_clk);
   endtask
   task automatic xmit(input logic [8:0] d);
      xmit_data <= d;
      xmit_load <= 1'b1;
      @(posedge sys_clk);
      xmit_load <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      // The reset must rise from low so that the asynchronous branches run at time zero.
      rst <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk(9'(xmit_ready), 9'h001);
      rd(`UCTL2_OFF_CTRL2, v);
      chk(v, 9'h000);
      rd(`UCTL2_OFF_STAT, v);
      chk(v & 9'h0c0, 9'h0c0);
      for (int i = 4; i < 8; i++) begin
         wr(`UCTL2_OFF_CTRL2, 8'(1 << i));
         rd(`UCTL2_OFF_CTRL2, v);
         chk(v, 9'(1 << i));
         chk(9'(irq), 9'(i >= 6));
      end
      wr(`UCTL2_OFF_BAUD, 8'h01);
      wr(`UCTL2_OFF_CTRL2, 8'h0c);
      repeat (4) @(posedge sys_clk);
      chk(9'(serial_out_oe_n), 9'h000);
      chk(9'(serial_in_owned), 9'h001);
      wr(`UCTL2_OFF_CTRL1, 8'ha2);
      repeat (4) @(posedge sys_clk);
      chk(9'(serial_in_owned), 9'h000);
      chk(9'(serial_out_oe_n), 9'h000);
      wr(`UCTL2_OFF_CTRL1, 8'ha0);
      repeat (4) @(posedge sys_clk);
      chk(9'(serial_out_oe_n), 9'h001);
      wr(`UCTL2_OFF_CTRL1, 8'h00);
      fork
         uctl2_remote_i.recv(w);
         begin
            xmit(9'h0a5);
            repeat (BIT) @(posedge sys_clk);
            rd(`UCTL2_OFF_STAT, v);
            chk(v & 9'h040, 9'h000);
         end
      join
      chk(9'(w), 9'h0a5);
      repeat (2 * BIT) @(posedge sys_clk);
      rd(`UCTL2_OFF_STAT, v);
      chk(v & 9'h0c0, 9'h0c0);
      xmit(9'h000);
      wr(`UCTL2_OFF_CTRL2, 8'h04);
      repeat (2 * BIT) @(posedge sys_clk);
      chk(9'(serial_out_oe_n), 9'h000);
      repeat (12 * BIT) @(posedge sys_clk);
      chk(9'(serial_out_oe_n), 9'h001);
      // Off then on with a byte still buffered queues an idle character, so done stays low past one frame.
      xmit(9'h000);
      wr(`UCTL2_OFF_CTRL2, 8'h04);
      wr(`UCTL2_OFF_CTRL2, 8'h0c);
      repeat (200) @(posedge sys_clk);
      rd(`UCTL2_OFF_STAT, v);
      chk(v & 9'h040, 9'h000);
      repeat (10 * BIT) @(posedge sys_clk);
      rd(`UCTL2_OFF_STAT, v);
      chk(v & 9'h040, 9'h040);
      // A second break may follow the first, so only the first low run is measured.
      for (int k = 0; k < 2; k++) begin
         wr(`UCTL2_OFF_CTRL1, k ? 8'h04 : 8'h00);
         wr(`UCTL2_OFF_CTRL2, 8'h0d);
         fork
            uctl2_remote_i.lowrun(n);
            wr(`UCTL2_OFF_CTRL2, 8'h0c);
         join
         chk(9'(n), k ? 9'h00d : 9'h00a);
         repeat (40 * BIT) @(posedge sys_clk);
      end
      wr(`UCTL2_OFF_CTRL2, 8'h2c);
      uctl2_remote_i.send(8'h5a);
      chk(rcv_data, 9'h05a);
      rd(`UCTL2_OFF_STAT, v);
      chk(v & 9'h020, 9'h020);
      chk(9'(irq), 9'h001);
      wr(`UCTL2_OFF_CTRL2, 8'h1c);
      repeat (12 * BIT) @(posedge sys_clk);
      rd(`UCTL2_OFF_STAT, v);
      chk(v & 9'h030, 9'h030);
      chk(9'(irq), 9'h001);
      rcv_taken <= 1'b1;
      @(posedge sys_clk);
      rcv_taken <= 1'b0;
      @(posedge sys_clk);
      chk(9'(irq), 9'h000);
      wr(`UCTL2_OFF_CTRL1, 8'h08);
      wr(`UCTL2_OFF_CTRL2, 8'h06);
      uctl2_remote_i.send(8'h12);
      rd(`UCTL2_OFF_CTRL2, v);
      chk(v, 9'h006);
      uctl2_remote_i.send(8'h92);
      rd(`UCTL2_OFF_CTRL2, v);
      chk(v, 9'h004);
      conclude();
   end
endmodule
bind uctl2_top uctl2_properties uctl2_properties_i (.sys_clk(sys_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata_r(reg_rdata_r), .xmit_ready(xmit_ready), .serial_out_oe_n(serial_out_oe_n),
   .serial_in_owned(serial_in_owned), .irq(irq));
